//--- core/ppm_pkg.sv
// Constants of the port 1 PHY register view: offsets, bit positions,
// reset values and the alias mapping between the two control layouts.
// Assumes a 16-bit register space addressed by printed byte offset.
package ppm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam int REG_ADDR_W = 12;
  localparam logic [11:0] OFS_MII_CTL = 12'h4D0;
  localparam logic [11:0] OFS_MII_STAT = 12'h4D2;
  localparam logic [11:0] OFS_ID_LOW = 12'h4D4;
  localparam logic [11:0] OFS_ID_HIGH = 12'h4D6;
  localparam logic [11:0] OFS_NAT_CTL4 = 12'h4F0;
  localparam logic [11:0] OFS_NAT_STAT = 12'h4F2;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h4F4;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h4F6;

  // ---------------------------------------------------------------
  // Basic control bit positions
  // ---------------------------------------------------------------
  localparam int CTL_LOOP = 14;
  localparam int CTL_F100 = 13;
  localparam int CTL_ANEN = 12;
  localparam int CTL_PDN = 11;
  localparam int CTL_RSTAN = 9;
  localparam int CTL_FDX = 8;
  localparam int CTL_XSEL = 5;
  localparam int CTL_FXO = 4;
  localparam int CTL_DXO = 3;
  localparam int CTL_DFEF = 2;
  localparam int CTL_DTX = 1;
  localparam int CTL_DLED = 0;
  // Bits held in storage; restart is a pulse and reads 0
  localparam logic [15:0] CTL_STORE_MASK = 16'h793F;
  localparam logic [15:0] CTL_RESET = 16'h1000;

  // ---------------------------------------------------------------
  // Native control four and native status bit positions
  // ---------------------------------------------------------------
  localparam int N4_LOOP = 8;
  localparam int N4_F100 = 6;
  localparam int N4_ANEN = 7;
  localparam int N4_PDN = 11;
  localparam int N4_RSTAN = 13;
  localparam int N4_FDX = 5;
  localparam int N4_FXO = 9;
  localparam int N4_DXO = 10;
  localparam int N4_DFEF = 12;
  localparam int N4_DTX = 14;
  localparam int N4_DLED = 15;
  localparam int NS_XSEL = 15;
  localparam int NS_FEF = 8;
  localparam int NS_ANDONE = 6;
  localparam int NS_LINK = 5;

  // ---------------------------------------------------------------
  // Basic status bit positions and fixed values
  // ---------------------------------------------------------------
  localparam logic [15:0] ST_FIXED = 16'h7800;
  localparam int ST_ANDONE = 5;
  localparam int ST_FEF = 4;
  localparam int ST_ANCAP = 3;
  localparam int ST_LINK = 2;

  // ---------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------
  localparam int EV_ANDONE = 0;
  localparam int EV_LINK = 1;
  localparam int EV_FEF = 2;
  localparam int EV_N = 3;
  localparam logic [EV_N-1:0] IRQ_MASK_RESET = 3'h0;

  // Basic control layout to native control four layout
  function automatic logic [15:0] mii_to_n4(input logic [15:0] m);
    logic [15:0] n;
    n = 16'h0000;
    n[N4_LOOP] = m[CTL_LOOP];
    n[N4_F100] = m[CTL_F100];
    n[N4_ANEN] = m[CTL_ANEN];
    n[N4_PDN] = m[CTL_PDN];
    n[N4_FDX] = m[CTL_FDX];
    n[N4_FXO] = m[CTL_FXO];
    n[N4_DXO] = m[CTL_DXO];
    n[N4_DFEF] = m[CTL_DFEF];
    n[N4_DTX] = m[CTL_DTX];
    n[N4_DLED] = m[CTL_DLED];
    return n;
  endfunction

  // Native control four layout to basic control layout
  function automatic logic [15:0] n4_to_mii(input logic [15:0] n);
    logic [15:0] m;
    m = 16'h0000;
    m[CTL_LOOP] = n[N4_LOOP];
    m[CTL_F100] = n[N4_F100];
    m[CTL_ANEN] = n[N4_ANEN];
    m[CTL_PDN] = n[N4_PDN];
    m[CTL_FDX] = n[N4_FDX];
    m[CTL_FXO] = n[N4_FXO];
    m[CTL_DXO] = n[N4_DXO];
    m[CTL_DFEF] = n[N4_DFEF];
    m[CTL_DTX] = n[N4_DTX];
    m[CTL_DLED] = n[N4_DLED];
    return m;
  endfunction

endpackage

//--- core/ppm_edge.sv
// Edge detector over a group of live status levels.
// Assumes levels synchronous to clock_in.
`timescale 1ns/10ps
module ppm_edge
  import ppm_pkg::*;
#(
  parameter int N = EV_N
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [N-1:0] level_in,
  output logic [N-1:0] rise_out,
  output logic [N-1:0] fall_out
);

  logic [N-1:0] prev_r;
  logic [N-1:0] prev_nxt;

  // Remember last level
  always_comb
  begin
    prev_nxt = level_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      prev_r <= '0;
    else
      prev_r <= prev_nxt;
  end

  // Per-bit edge pulses
  for (genvar i = 0; i < N; i++)
  begin : g_edge
    assign rise_out[i] = level_in[i] & ~prev_r[i];
    assign fall_out[i] = ~level_in[i] & prev_r[i];
  end

endmodule

//--- core/ppm_irq.sv
// Sticky event flags with mask and one level interrupt.
// Assumes set and clear pulses synchronous to clock_in.
`timescale 1ns/10ps
module ppm_irq
  import ppm_pkg::*;
#(
  parameter int N = EV_N
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  input wire logic [N-1:0] mask_in,
  output logic [N-1:0] status_out,
  output logic irq_out
);

  logic [N-1:0] flag_r;
  logic [N-1:0] flag_nxt;

  // A set in the clearing cycle survives
  always_comb
  begin
    flag_nxt = (flag_r & ~clr_in) | set_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      flag_r <= '0;
    else
      flag_r <= flag_nxt;
  end

  assign status_out = flag_r;
  assign irq_out = |(flag_r & mask_in);

endmodule

//--- core/ppm_regs.sv
// Port 1 PHY register view: basic control and status, identifier
// words, native control four and native status aliases, interrupts.
// Assumes a simple strobe bus and live PHY levels on clock_in.
//
// Summary of operation
// R1 - Control bit 14 loops received data back toward transmit.
// R2 - Control bit 13 forces 100 or 10 Mbps when negotiation off.
// R3 - Control bit 12 enables auto-negotiation; resets to one.
// R4 - Writing one to control bit 9 restarts auto-negotiation.
// R5 - Control bit 8 forces full or half duplex when negotiation off.
// R6 - Control bit 5 picks the crossover algorithm; resets to zero.
// R7 - Bit 4 forces crossed pairs; bit 3 disables auto crossover.
// R8 - Control bit 2 disables far-end-fault detection.
// R9 - Bit 1 disables transmitter, bit 0 disables LED; reset clear.
// R10 - Status bits 14 to 11 always read one.
// R11 - Status bits 15 and 0 read zero.
// R12 - Status bits 5, 4, 2 show negotiation done, fault, link.
// R13 - Status bit 3 follows negotiation enable, resets to one.
// R14 - Identifier low word reads a constant; writes ignored.
// R15 - Identifier high word reads a constant; writes ignored.
// R16 - Native and basic views share storage and read coherently.
// R17 - Unsupported and reserved bits read zero, ignore writes.
`timescale 1ns/10ps
module ppm_regs
  import ppm_pkg::*;
#(
  parameter int ADDR_W = REG_ADDR_W,
  // Identifier words; values are arbitrary
  parameter logic [15:0] PHY_ID_LOW = 16'h5A5A,
  parameter logic [15:0] PHY_ID_HIGH = 16'hA5C3
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  // Live PHY condition
  input wire logic link_up_in,
  input wire logic autoneg_done_in,
  input wire logic far_end_fault_in,
  // PHY control
  output logic loopback_out,
  output logic force_100_out,
  output logic autoneg_enable_out,
  output logic power_down_out,
  output logic autoneg_restart_out,
  output logic force_full_duplex_out,
  output logic crossover_algorithm_select_out,
  output logic force_crossed_out,
  output logic auto_crossover_disable_out,
  output logic far_end_fault_disable_out,
  output logic transmit_disable_out,
  output logic led_disable_out,
  // Interrupt
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W < REG_ADDR_W)
  begin : g_chk
    $error("ppm_regs: address port too narrow for the map");
  end

  // A stored restart bit would read back as one and never end its pulse
  if (CTL_STORE_MASK[CTL_RSTAN] != 1'b0)
  begin : g_chk_restart
    $error("ppm_regs: restart bit must stay out of storage");
  end

  // A reset value outside storage could never be written back
  if ((CTL_RESET & ~CTL_STORE_MASK) != 16'h0000)
  begin : g_chk_reset
    $error("ppm_regs: control reset sets an unstored bit");
  end

  // Live status bits must not overlap the fixed capability field
  if (ST_FIXED[ST_ANDONE] || ST_FIXED[ST_FEF] || ST_FIXED[ST_ANCAP] ||
    ST_FIXED[ST_LINK])
  begin : g_chk_status
    $error("ppm_regs: live status bit overlaps a fixed bit");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic restart_r;
  logic restart_nxt;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  logic [EV_N-1:0] mask_r;
  logic [EV_N-1:0] mask_nxt;
  logic [15:0] mii_stat;
  logic [15:0] nat_stat;
  logic [15:0] nat_ctl4;
  logic fef_live;
  logic [EV_N-1:0] ev_level;
  logic [EV_N-1:0] ev_rise;
  logic [EV_N-1:0] ev_fall;
  logic [EV_N-1:0] ev_set;
  logic [EV_N-1:0] ev_clr;
  logic [EV_N-1:0] ev_status;
  logic wr_mii_ctl;
  logic wr_nat_ctl4;
  logic wr_nat_stat;
  logic wr_irq_mask;
  logic rd_irq_stat;

  // Address match against a printed offset
  function automatic logic hit(input logic [11:0] ofs);
    return addr_in == ADDR_W'(ofs);
  endfunction

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------

  // Write strobes per writable register
  assign wr_mii_ctl = wr_en_in && hit(OFS_MII_CTL);
  assign wr_nat_ctl4 = wr_en_in && hit(OFS_NAT_CTL4);
  assign wr_nat_stat = wr_en_in && hit(OFS_NAT_STAT);
  assign wr_irq_mask = wr_en_in && hit(OFS_IRQ_MASK);

  // Read strobe that clears the event flags
  assign rd_irq_stat = rd_en_in && hit(OFS_IRQ_STAT);

  // ---------------------------------------------------------------
  // Control storage
  // ---------------------------------------------------------------

  // Both layouts land in the one control word
  always_comb
  begin
    ctl_nxt = ctl_r;
    if (wr_mii_ctl)
    begin
      // Unsupported bits dropped on the way in
      ctl_nxt = wr_data_in & CTL_STORE_MASK; // R17
    end
    else if (wr_nat_ctl4)
    begin
      // Crossover select lives in the native status view
      ctl_nxt = n4_to_mii(wr_data_in) & CTL_STORE_MASK; // R16
      ctl_nxt[CTL_XSEL] = ctl_r[CTL_XSEL];
    end
    else if (wr_nat_stat)
    begin
      ctl_nxt[CTL_XSEL] = wr_data_in[NS_XSEL]; // R16
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      ctl_r <= CTL_RESET; // R3 R6 R9
    else
      ctl_r <= ctl_nxt;
  end

  // ---------------------------------------------------------------
  // Restart pulse
  // ---------------------------------------------------------------

  // Either view can request a restart; the bit self-clears
  always_comb
  begin
    restart_nxt = 1'b0;
    if (wr_mii_ctl)
      restart_nxt = wr_data_in[CTL_RSTAN]; // R4
    else if (wr_nat_ctl4)
      restart_nxt = wr_data_in[N4_RSTAN]; // R4 R16
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      restart_r <= 1'b0;
    else
      restart_r <= restart_nxt;
  end

  // ---------------------------------------------------------------
  // Status words
  // ---------------------------------------------------------------

  // Fault report is suppressed while detection is disabled
  assign fef_live = far_end_fault_in & ~ctl_r[CTL_DFEF]; // R8

  // Basic status: fixed capability plus live conditions
  always_comb
  begin
    mii_stat = ST_FIXED; // R10 R11 R17
    mii_stat[ST_ANDONE] = autoneg_done_in; // R12
    mii_stat[ST_FEF] = fef_live; // R12
    mii_stat[ST_ANCAP] = ctl_r[CTL_ANEN]; // R13
    mii_stat[ST_LINK] = link_up_in; // R12
  end

  // Native status: same live bits at their native places
  always_comb
  begin
    nat_stat = 16'h0000;
    nat_stat[NS_XSEL] = ctl_r[CTL_XSEL]; // R16
    nat_stat[NS_FEF] = fef_live;
    nat_stat[NS_ANDONE] = autoneg_done_in;
    nat_stat[NS_LINK] = link_up_in;
  end

  // Native control four is a rearranged copy of the control word
  assign nat_ctl4 = mii_to_n4(ctl_r); // R16

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------

  // Read data stands for the one cycle after the strobe
  always_comb
  begin
    rd_data_nxt = 16'h0000;
    if (rd_en_in)
    begin
      if (hit(OFS_MII_CTL))
        rd_data_nxt = ctl_r;
      else if (hit(OFS_MII_STAT))
        rd_data_nxt = mii_stat;
      else if (hit(OFS_ID_LOW))
        rd_data_nxt = PHY_ID_LOW; // R14
      else if (hit(OFS_ID_HIGH))
        rd_data_nxt = PHY_ID_HIGH; // R15
      else if (hit(OFS_NAT_CTL4))
        rd_data_nxt = nat_ctl4;
      else if (hit(OFS_NAT_STAT))
        rd_data_nxt = nat_stat;
      else if (hit(OFS_IRQ_STAT))
        rd_data_nxt = {13'h0000, ev_status};
      else if (hit(OFS_IRQ_MASK))
        rd_data_nxt = {13'h0000, mask_r};
      else
        rd_data_nxt = 16'h0000; // Unmapped reads as zero
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rd_data_r <= 16'h0000;
    else
      rd_data_r <= rd_data_nxt;
  end

  assign rd_data_out = rd_data_r;

  // ---------------------------------------------------------------
  // Interrupt mask
  // ---------------------------------------------------------------

  // Mask occupies the low bits; upper bits ignore writes
  always_comb
  begin
    mask_nxt = mask_r;
    if (wr_irq_mask)
      mask_nxt = wr_data_in[EV_N-1:0];
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      mask_r <= IRQ_MASK_RESET;
    else
      mask_r <= mask_nxt;
  end

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------

  // Live levels watched for change
  always_comb
  begin
    ev_level = '0;
    ev_level[EV_ANDONE] = autoneg_done_in;
    ev_level[EV_LINK] = link_up_in;
    ev_level[EV_FEF] = fef_live;
  end

  ppm_edge #(
    .N(EV_N)
  ) u_edge (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .level_in(ev_level),
    .rise_out(ev_rise),
    .fall_out(ev_fall)
  );

  // Completion and fault on rise, link on either edge
  always_comb
  begin
    ev_set = ev_rise;
    ev_set[EV_LINK] = ev_rise[EV_LINK] | ev_fall[EV_LINK];
  end

  // Reading the status word clears every flag it returned
  assign ev_clr = {EV_N{rd_irq_stat}};

  ppm_irq #(
    .N(EV_N)
  ) u_irq (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(ev_set),
    .clr_in(ev_clr),
    .mask_in(mask_r),
    .status_out(ev_status),
    .irq_out(irq_out)
  );

  // ---------------------------------------------------------------
  // PHY control outputs
  // ---------------------------------------------------------------

  // Straight from the control flops
  assign loopback_out = ctl_r[CTL_LOOP]; // R1
  assign force_100_out = ctl_r[CTL_F100]; // R2
  assign autoneg_enable_out = ctl_r[CTL_ANEN]; // R3
  assign power_down_out = ctl_r[CTL_PDN];
  assign autoneg_restart_out = restart_r; // R4
  assign force_full_duplex_out = ctl_r[CTL_FDX]; // R5
  assign crossover_algorithm_select_out = ctl_r[CTL_XSEL]; // R6
  assign force_crossed_out = ctl_r[CTL_FXO]; // R7
  assign auto_crossover_disable_out = ctl_r[CTL_DXO]; // R7
  assign far_end_fault_disable_out = ctl_r[CTL_DFEF]; // R8
  assign transmit_disable_out = ctl_r[CTL_DTX]; // R9
  assign led_disable_out = ctl_r[CTL_DLED]; // R9

endmodule

//--- sim/ppm_regs_chk.sv
// Assertions on the ports of the port 1 PHY register view.
// Assumes the bus never raises both strobes in one cycle.
`timescale 1ns/10ps
module ppm_regs_chk
  import ppm_pkg::*;
#(
  parameter int ADDR_W = REG_ADDR_W,
  parameter logic [15:0] PHY_ID_LOW = 16'h0000,
  parameter logic [15:0] PHY_ID_HIGH = 16'h0000
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic link_up_in,
  input wire logic autoneg_done_in,
  input wire logic far_end_fault_in,
  input wire logic loopback_out,
  input wire logic force_100_out,
  input wire logic autoneg_enable_out,
  input wire logic autoneg_restart_out,
  input wire logic force_full_duplex_out,
  input wire logic crossover_algorithm_select_out,
  input wire logic force_crossed_out,
  input wire logic auto_crossover_disable_out,
  input wire logic far_end_fault_disable_out,
  input wire logic transmit_disable_out,
  input wire logic led_disable_out
);
  // ------------------------------------------------------------
  // Access decode and control pins
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  // Accesses of interest
  wire logic wr_ctl = wr_en_in && addr_in == OFS_MII_CTL;
  wire logic rd_st = rd_en_in && addr_in == OFS_MII_STAT;
  wire logic rd_lo = rd_en_in && addr_in == OFS_ID_LOW;
  wire logic rd_hi = rd_en_in && addr_in == OFS_ID_HIGH;
  // Stored control bits other than power down as seen on the pins
  wire logic [9:0] pins = {loopback_out, force_100_out,
    autoneg_enable_out, force_full_duplex_out,
    crossover_algorithm_select_out, force_crossed_out,
    auto_crossover_disable_out, far_end_fault_disable_out,
    transmit_disable_out, led_disable_out};

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_loop_write:
    assert property (wr_ctl |=> pins[9] == $past(wr_data_in[14]))
    else $error("loopback does not follow a control write");
  a_speed_duplex:
    assert property (wr_ctl |=> {pins[8], pins[6]} ==
      $past({wr_data_in[13], wr_data_in[8]}))
    else $error("speed or duplex does not follow a control write");
  a_anen_write:
    assert property (wr_ctl |=> pins[7] == $past(wr_data_in[12]))
    else $error("negotiation enable does not follow a write");
  a_xover_write:
    assert property (wr_ctl |=> pins[5:3] == $past(wr_data_in[5:3]))
    else $error("crossover bits do not follow a control write");
  a_disable_write:
    assert property (wr_ctl |=> pins[2:0] == $past(wr_data_in[2:0]))
    else $error("disable bits do not follow a control write");
  a_restart_pulse:
    assert property (wr_ctl && wr_data_in[9] |=>
      autoneg_restart_out ##1 (!autoneg_restart_out || $past(wr_en_in)))
    else $error("restart is not a one cycle pulse");
  a_restart_cause:
    assert property (autoneg_restart_out |-> $past(wr_en_in))
    else $error("restart pulse without a write");
  a_pins_hold:
    assert property (!wr_en_in |=> $stable(pins))
    else $error("control pins moved without a write");
  a_status_fixed:
    assert property (rd_st |=> rd_data_out[15:6] == 10'h1E0 &&
      rd_data_out[1:0] == 2'h0)
    else $error("fixed status bits wrong");
  a_status_live:
    assert property (rd_st |=> rd_data_out[5:2] ==
      $past({autoneg_done_in, far_end_fault_in && !pins[2],
      pins[7], link_up_in}))
    else $error("live status bits wrong");
  a_ident_low:
    assert property (rd_lo |=> rd_data_out == PHY_ID_LOW)
    else $error("identifier low word wrong");
  a_ident_high:
    assert property (rd_hi |=> rd_data_out == PHY_ID_HIGH)
    else $error("identifier high word wrong");
  a_read_idle:
    assert property (!rd_en_in |=> rd_data_out == 16'h0000)
    else $error("read data present without a read");
  a_reset_state:
    assert property ($fell(sys_rst_in) |-> pins == 10'h080)
    else $error("control pins wrong after reset");
endmodule

bind ppm_regs ppm_regs_chk #(.ADDR_W(ADDR_W), .PHY_ID_LOW(PHY_ID_LOW),
  .PHY_ID_HIGH(PHY_ID_HIGH)) u_ppm_regs_chk (.clock_in, .sys_rst_in,
  .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out,
  .link_up_in, .autoneg_done_in, .far_end_fault_in, .loopback_out,
  .force_100_out, .autoneg_enable_out, .autoneg_restart_out,
  .force_full_duplex_out, .crossover_algorithm_select_out,
  .force_crossed_out, .auto_crossover_disable_out,
  .far_end_fault_disable_out, .transmit_disable_out, .led_disable_out);

//--- sim/ppm_regs_tb_top.sv
// Self-checking bench of the port 1 PHY register view.
// Assumes ppm_regs with its checker bound; one 100 MHz clock.
`timescale 1ns/10ps
module ppm_regs_tb_top
  import ppm_pkg::*;
;
  // Identifier words; values are arbitrary
  localparam logic [15:0] ID_L = 16'h3C96;
  localparam logic [15:0] ID_H = 16'h69E1;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0, rd_en = 1'b0;
  logic link = 1'b0, neg_done = 1'b0, fef = 1'b0;
  logic [15:0] rdata, rv;
  logic lp, f1, ane, pd, rso, fd, xs, fx, dx, df, dt, dl, irq, rs;
  int fails = 0, checks = 0, cycles = 0;

  // ------------------------------------------------------------
  // Clock, design and timeout
  // ------------------------------------------------------------
  always #5 clock_in = ~clock_in;
  ppm_regs #(.PHY_ID_LOW(ID_L), .PHY_ID_HIGH(ID_H)) u_ppm_regs (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rdata), .link_up_in(link), .autoneg_done_in(neg_done),
    .far_end_fault_in(fef), .loopback_out(lp), .force_100_out(f1),
    .autoneg_enable_out(ane), .power_down_out(pd),
    .autoneg_restart_out(rso), .force_full_duplex_out(fd),
    .crossover_algorithm_select_out(xs), .force_crossed_out(fx),
    .auto_crossover_disable_out(dx), .far_end_fault_disable_out(df),
    .transmit_disable_out(dt), .led_disable_out(dl), .irq_out(irq));
  // Cuts a hang short
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  // Control pins placed at their control bit positions
  function automatic logic [15:0] pins();
    return {1'b0, lp, f1, ane, pd, 2'b00, fd, 2'b00, xs, fx, dx, df, dt,
      dl};
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock_in);
    wr_en <= 1'b0;
    #1 rs = rso;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rd_en <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic inputs(input logic l, input logic d, input logic f);
    @(posedge clock_in);
    link <= l;
    neg_done <= d;
    fef <= f;
    repeat (2) @(posedge clock_in);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_MII_CTL);
    chk("ctl reset", CTL_RESET, rv);
    chk("pins reset", CTL_RESET, pins());
    rd(OFS_MII_STAT);
    chk("status reset", 16'h7808, rv);
    rd(OFS_IRQ_MASK);
    chk("mask reset", 16'h0000, rv);
  endtask
  task automatic t_ctl_bits();
    logic [15:0] e;
    for (int i = 0; i < 17; i++)
    begin
      e = (i == 16) ? 16'hFFFF : 16'h0001 << i;
      wr(OFS_MII_CTL, e);
      chk("restart", {15'h0, e[9]}, {15'h0, rs});
      chk("ctl pins", e & 16'h793F, pins());
      rd(OFS_MII_CTL);
      chk("ctl read", e & 16'h793F, rv);
    end
  endtask
  task automatic t_status();
    wr(OFS_MII_CTL, 16'h0004);
    inputs(1'b1, 1'b1, 1'b1);
    rd(OFS_MII_STAT);
    chk("status gated", 16'h7824, rv);
    wr(OFS_MII_CTL, 16'h1000);
    rd(OFS_MII_STAT);
    chk("status live", 16'h783C, rv);
    inputs(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_ident();
    wr(OFS_ID_LOW, 16'hFFFF);
    wr(OFS_ID_HIGH, 16'h0000);
    wr(12'h4C0, 16'hFFFF);
    rd(OFS_ID_LOW);
    chk("id low", ID_L, rv);
    rd(OFS_ID_HIGH);
    chk("id high", ID_H, rv);
    rd(12'h4C0);
    chk("unmapped", 16'h0000, rv);
    rd(OFS_MII_CTL);
    chk("ctl kept", 16'h1000, rv);
  endtask
  task automatic t_alias();
    wr(OFS_NAT_CTL4, 16'h8100);
    rd(OFS_MII_CTL);
    chk("alias ctl", 16'h4001, rv);
    rd(OFS_NAT_CTL4);
    chk("native ctl", 16'h8100, rv);
    wr(OFS_NAT_STAT, 16'h8000);
    rd(OFS_MII_CTL);
    chk("alias xsel", 16'h4021, rv);
    chk("alias pins", 16'h4021, pins());
    rd(OFS_NAT_STAT);
    chk("native xsel", 16'h8000, rv);
    wr(OFS_MII_CTL, 16'h0000);
    rd(OFS_NAT_STAT);
    chk("alias nat", 16'h0000, rv);
    wr(OFS_NAT_CTL4, 16'h2000);
    chk("nat restart", 16'h0001, {15'h0, rs});
  endtask
  task automatic t_irq();
    rd(OFS_IRQ_STAT);
    wr(OFS_IRQ_MASK, 16'h0002);
    inputs(1'b1, 1'b1, 1'b1);
    chk("irq on", 16'h0001, {15'h0, irq});
    rd(OFS_IRQ_STAT);
    chk("events", 16'h0007, rv);
    chk("irq off", 16'h0000, {15'h0, irq});
    wr(OFS_IRQ_MASK, 16'h0000);
    inputs(1'b0, 1'b1, 1'b1);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(OFS_IRQ_MASK, 16'h0002);
    chk("irq unmasked", 16'h0001, {15'h0, irq});
    rd(OFS_IRQ_STAT);
    chk("link fall", 16'h0002, rv);
    rd(OFS_IRQ_STAT);
    chk("cleared", 16'h0000, rv);
  endtask

  // ------------------------------------------------------------
  // Main sequence and verdict
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_ctl_bits();
    t_status();
    t_ident();
    t_alias();
    t_irq();
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    inputs(1'b0, 1'b0, 1'b0);
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset();
    end_of_test();
  end
endmodule
